/* rtl/fpsmc_top.sv */
/*
 * Front panel selector and mute control: button and remote command
 * decoding, source routing, output selection, forced muting, standby and
 * indicator drive, plus a small register port for software.
 * Assumes all pin inputs are asynchronous to i_mclk and that the register
 * port is driven from logic on i_mclk.
 */
// Summary of operation
// - Four digital buttons pick the digital receiver input
// - Last digital pick stays lit and routed
// - Most recent of eight buttons is heard
// - Phase toggles per press, digital only
// - Rate indicator lit only when locked valid
// - Encoded indicator only when encoded and decoding
// - Command indicator flashes on every valid command outside standby
// - Dim when unselected, bright when selected
// - Insert toggles, return replaces selected source
// - Primary output live unless muted
// - Default: one of outputs two, three
// - Jumper lets outputs toggle independently
// - Jumper turns remote phase into output two
// - User mute toggles per press
// - Warm-up mute after power-up; mute on loss
// - Mute on digital pick and bad data
// - Standby removes power to controlled loads
// - Standby keeps settings, still takes commands
// - Standby: standby dim, all else dark
// - Leaving standby restores, reapplies warm-up mute
// - Supply loss loses settings
// - Remote commands act like panel buttons
module fpsmc_top #(
	parameter longint unsigned WARM_CYC  = fpsmc_pkg::WARM_CYC,
	parameter longint unsigned DEB_CYC   = fpsmc_pkg::DEB_CYC,
	parameter longint unsigned FLASH_CYC = fpsmc_pkg::FLASH_CYC
) (
	input  wire logic                 i_mclk,
	input  wire logic                 i_nrst,
	input  wire fpsmc_pkg::fpsmc_pin_t i_pins,
	input  wire logic [3:0]           i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic [31:0]               o_rdata,
	output logic [1:0]                o_dig_route,
	output logic [2:0]                o_listen_sel,
	output logic                      o_src_valid,
	output logic                      o_phase_inv,
	output logic                      o_insert,
	output logic                      o_out2_en,
	output logic                      o_out3_en,
	output logic                      o_mute,
	output logic                      o_power_en,
	output logic                      o_vol_up,
	output logic                      o_vol_dn,
	output fpsmc_pkg::fpsmc_led_t     o_led,
	output logic [fpsmc_pkg::NRATE-1:0] o_rate_led,
	output logic                      o_enc_led
);
	// ----------------------------------------------------------------
	// Elaboration checks and widths
	// ----------------------------------------------------------------
	localparam int NDEB = fpsmc_pkg::NBTN + 1;          // Buttons plus remote valid
	localparam int WW   = $clog2(WARM_CYC + 1);
	localparam int DW   = $clog2(DEB_CYC + 1);
	localparam int FW   = $clog2(FLASH_CYC + 1);

	initial
	begin
		if (WARM_CYC < 1 || DEB_CYC < 1 || FLASH_CYC < 1)
			$error("fpsmc_top: counts must be at least one cycle");
		if (WW > 40)
			$error("fpsmc_top: warm-up count too large");
	end

	// Brightness of a function indicator from its selection
	function automatic fpsmc_pkg::fpsmc_lvl_t lvl(input logic sel);
		lvl = sel ? fpsmc_pkg::FPSMC_BRIGHT : fpsmc_pkg::FPSMC_DIM;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	fpsmc_pkg::fpsmc_pin_t pin_m;   // First stage, read only by pin_s
	fpsmc_pkg::fpsmc_pin_t pin_s;   // Second stage, safe to use

	// Two flops on every asynchronous pin
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			pin_m <= '0;
			pin_s <= '0;
		end
		else
		begin
			pin_m <= i_pins;
			pin_s <= pin_m;
		end
	end

	// ----------------------------------------------------------------
	// Debounce
	// ----------------------------------------------------------------
	logic [NDEB-1:0] raw;                // Synchronised press levels
	logic [NDEB-1:0] deb;                // Debounced levels
	logic [NDEB-1:0] deb_d;              // Debounced, one cycle late
	logic [DW-1:0]   deb_cnt [NDEB];     // Stability counters
	logic [NDEB-1:0] press;              // One-cycle press pulses

	assign raw   = {pin_s.rc_valid, pin_s.btn};
	assign press = deb & ~deb_d;

	// A level must hold for the full time before it is believed, so contact
	// bounce and remote repeat gaps cannot yield a second press
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			deb   <= '0;
			deb_d <= '0;
			for (int i = 0; i < NDEB; i++)
				deb_cnt[i] <= '0;
		end
		else
		begin
			deb_d <= deb;
			for (int i = 0; i < NDEB; i++)
			begin
				if (raw[i] == deb[i])
					deb_cnt[i] <= '0;
				else if (deb_cnt[i] == DW'(DEB_CYC - 1))
				begin
					deb[i]     <= raw[i];
					deb_cnt[i] <= '0;
				end
				else
					deb_cnt[i] <= deb_cnt[i] + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command arbitration
	// ----------------------------------------------------------------
	logic                   cmd_fire;    // One command this cycle
	fpsmc_pkg::fpsmc_cmd_t  cmd;         // Its code
	logic                   cmd_remote;  // It came from the remote
	fpsmc_pkg::fpsmc_cmd_t  last_cmd;    // Last command, for software
	logic                   wr_cmd;      // Software command write

	assign wr_cmd = i_wr && (i_addr == fpsmc_pkg::REG_COMMAND);

	// Software beats remote beats panel; same-cycle losers are dropped,
	// which a human hand cannot notice. Lowest button wins among buttons.
	always_comb
	begin
		cmd_fire   = 1'b0;
		cmd        = fpsmc_pkg::FPSMC_DIG0;
		cmd_remote = 1'b0;
		if (wr_cmd)
		begin
			cmd_fire = 1'b1;
			cmd      = fpsmc_pkg::fpsmc_cmd_t'(i_wdata[fpsmc_pkg::CMD_W-1:0]);
		end
		else if (press[NDEB-1])
		begin
			cmd_fire   = 1'b1;
			cmd        = fpsmc_pkg::fpsmc_cmd_t'(pin_s.rc_code);
			cmd_remote = 1'b1;
		end
		else
		begin
			for (int i = fpsmc_pkg::NBTN - 1; i >= 0; i--)
			begin
				if (press[i])
				begin
					cmd_fire = 1'b1;
					cmd      = fpsmc_pkg::fpsmc_cmd_t'(i[fpsmc_pkg::CMD_W-1:0]);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Held settings
	// ----------------------------------------------------------------
	logic [1:0] dig_sel;    // Last digital input picked
	logic [1:0] ana_sel;    // Last analog input picked
	logic       on_ana;     // Listening to analog
	logic       have_src;   // Any source picked since supply up
	logic       phase;      // Polarity inversion
	logic       insert;     // Insert loop active
	logic       out2;       // Second output enabled
	logic       out3;       // Third output enabled
	logic       umute;      // User mute
	logic       standby;    // Standby mode

	// Settings change on commands in standby too; only loads lose power.
	// Reset stands for supply arrival, so nothing survives it.
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			dig_sel  <= 2'h0;
			ana_sel  <= 2'h0;
			on_ana   <= 1'b0;
			have_src <= 1'b0;
			phase    <= 1'b0;
			insert   <= 1'b0;
			out2     <= 1'b0;
			out3     <= 1'b1;
			umute    <= 1'b0;
			standby  <= 1'b0;
		end
		else if (cmd_fire)
		begin
			case (cmd)
				fpsmc_pkg::FPSMC_DIG0, fpsmc_pkg::FPSMC_DIG1,
				fpsmc_pkg::FPSMC_DIG2, fpsmc_pkg::FPSMC_DIG3:
				begin
					dig_sel  <= cmd[1:0];
					on_ana   <= 1'b0;
					have_src <= 1'b1;
				end
				fpsmc_pkg::FPSMC_ANA0, fpsmc_pkg::FPSMC_ANA1,
				fpsmc_pkg::FPSMC_ANA2, fpsmc_pkg::FPSMC_ANA3:
				begin
					ana_sel  <= cmd[1:0];
					on_ana   <= 1'b1;
					have_src <= 1'b1;
				end
				fpsmc_pkg::FPSMC_PHASE:
				begin
					if (pin_s.indep && cmd_remote)
						out2 <= ~out2;
					else
						phase <= ~phase;
				end
				fpsmc_pkg::FPSMC_INSERT:
					insert <= ~insert;
				fpsmc_pkg::FPSMC_OUT2, fpsmc_pkg::FPSMC_OUT3:
				begin
					if (pin_s.indep)
					begin
						if (cmd == fpsmc_pkg::FPSMC_OUT2)
							out2 <= ~out2;
						else
							out3 <= ~out3;
					end
					else
					begin
						out2 <= ~out2;
						out3 <= out2;
					end
				end
				fpsmc_pkg::FPSMC_MUTE:
					umute <= ~umute;
				fpsmc_pkg::FPSMC_STANDBY:
					standby <= ~standby;
				default:
					; // Volume codes handled below
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Forced mute sources
	// ----------------------------------------------------------------
	logic [WW-1:0] warm_cnt;   // Warm-up time left
	logic          dig_hold;   // Fresh digital pick, not yet locked
	logic          data_ok;    // Receiver locked onto valid data
	logic          dig_force;  // Digital path must be silenced

	assign data_ok   = pin_s.lock && pin_s.dvalid;
	assign dig_force = have_src && !on_ana && (dig_hold || !data_ok);

	// Reload on supply arrival and on leaving standby
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			warm_cnt <= WW'(WARM_CYC);
		else if (standby || (cmd_fire && cmd == fpsmc_pkg::FPSMC_STANDBY))
			warm_cnt <= WW'(WARM_CYC);
		else if (warm_cnt != '0)
			warm_cnt <= warm_cnt - 1'b1;
	end

	// A fresh pick mutes at least one cycle, then until good data is seen;
	// the set wins over the clear when both fall in one cycle
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			dig_hold <= 1'b0;
		else if (cmd_fire && cmd <= fpsmc_pkg::FPSMC_DIG3)
			dig_hold <= 1'b1;
		else if (data_ok)
		begin
			dig_hold <= 1'b0; // Receiver reports good data again
		end
	end

	// ----------------------------------------------------------------
	// Command flash and volume motor
	// ----------------------------------------------------------------
	logic [FW-1:0] flash_cnt;  // Command indicator time left

	// Restarted by every command, so rapid presses keep it lit
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			flash_cnt <= '0;
		else if (cmd_fire)
			flash_cnt <= FW'(FLASH_CYC);
		else if (flash_cnt != '0)
			flash_cnt <= flash_cnt - 1'b1;
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	logic mute_any;   // Any mute condition
	logic lit;        // Indicators powered

	assign lit      = !standby;
	assign mute_any = umute || (warm_cnt != '0) || dig_force || !pin_s.pgood || standby;

	// Routing and power follow the held settings one cycle later
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			o_dig_route  <= 2'h0;
			o_listen_sel <= 3'h0;
			o_src_valid  <= 1'b0;
			o_phase_inv  <= 1'b0;
			o_insert     <= 1'b0;
			o_out2_en    <= 1'b0;
			o_out3_en    <= 1'b0;
			o_mute       <= 1'b1;
			o_power_en   <= 1'b0;
			o_vol_up     <= 1'b0;
			o_vol_dn     <= 1'b0;
		end
		else
		begin
			o_dig_route  <= dig_sel;
			o_listen_sel <= on_ana ? {1'b1, ana_sel} : {1'b0, dig_sel};
			o_src_valid  <= have_src;
			o_phase_inv  <= phase && !on_ana;
			o_insert     <= insert;
			o_out2_en    <= out2 && lit;
			o_out3_en    <= out3 && lit;
			o_mute       <= mute_any;
			o_power_en   <= lit;
			o_vol_up     <= deb[NDEB-1] && pin_s.rc_code == fpsmc_pkg::FPSMC_VOLUP;
			o_vol_dn     <= deb[NDEB-1] && pin_s.rc_code == fpsmc_pkg::FPSMC_VOLDN;
		end
	end

	// Indicator drive: all dark in standby except the standby lamp, dim
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			o_led      <= '0;
			o_rate_led <= '0;
			o_enc_led  <= 1'b0;
		end
		else if (!lit)
		begin
			o_led         <= '0;
			o_led.standby <= fpsmc_pkg::FPSMC_DIM;
			o_rate_led    <= '0;
			o_enc_led     <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				o_led.dig[i] <= lvl(have_src && dig_sel == i[1:0]);
				o_led.ana[i] <= lvl(have_src && on_ana && ana_sel == i[1:0]);
			end
			o_led.phase   <= lvl(phase);
			o_led.insert  <= lvl(insert);
			o_led.out2    <= lvl(out2);
			o_led.out3    <= lvl(out3);
			o_led.mute    <= lvl(mute_any);
			o_led.standby <= fpsmc_pkg::FPSMC_DIM;
			o_led.command <= (flash_cnt != '0) ? fpsmc_pkg::FPSMC_BRIGHT : fpsmc_pkg::FPSMC_OFF;
			for (int r = 0; r < fpsmc_pkg::NRATE; r++)
				o_rate_led[r] <= data_ok && pin_s.rate == r[1:0];
			o_enc_led     <= data_ok && pin_s.enc && pin_s.dec;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			last_cmd <= fpsmc_pkg::FPSMC_DIG0;
		else if (cmd_fire)
			last_cmd <= cmd;
	end

	// Read data valid in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			o_rdata <= 32'h0;
		else if (!i_rd)
			o_rdata <= 32'h0;
		else if (i_addr == fpsmc_pkg::REG_SETTINGS)
			o_rdata <= {20'h0, standby, umute, out3, out2, insert, phase,
				have_src, on_ana, ana_sel, dig_sel};
		else if (i_addr == fpsmc_pkg::REG_LINKSTAT)
			o_rdata <= {23'h0, (warm_cnt != '0), mute_any, pin_s.pgood, pin_s.indep,
				pin_s.dec, pin_s.enc, pin_s.lock, pin_s.dvalid, 1'b0};
		else if (i_addr == fpsmc_pkg::REG_COMMAND)
			o_rdata <= {28'h0, last_cmd};
		else
			o_rdata <= 32'h0;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	AST_WARM_MUTE: assert property ((warm_cnt != '0) |=> o_mute)
		else $error("output live during warm-up");
	AST_STBY_DARK: assert property (standby |=> (o_led.mute == fpsmc_pkg::FPSMC_OFF
		&& o_led.standby == fpsmc_pkg::FPSMC_DIM && o_rate_led == '0))
		else $error("indicator lit in standby");
	AST_STBY_PWR: assert property (standby |=> !o_power_en && o_mute)
		else $error("loads powered in standby");
	AST_PHASE_TGL: assert property (cmd_fire && cmd == fpsmc_pkg::FPSMC_PHASE && !cmd_remote
		|=> phase != $past(phase))
		else $error("phase did not toggle");
	AST_REMOTE_OUT2: assert property (cmd_fire && cmd == fpsmc_pkg::FPSMC_PHASE && cmd_remote
		&& pin_s.indep |=> $stable(phase) && out2 != $past(out2))
		else $error("remote phase not rerouted");
	AST_OUT_SWAP: assert property (cmd_fire && !standby && !pin_s.indep && (cmd == fpsmc_pkg::FPSMC_OUT2
		|| cmd == fpsmc_pkg::FPSMC_OUT3) |=> out2 != out3 ##1 o_out2_en != o_out3_en)
		else $error("outputs not exclusive");
	AST_DIG_KEEP: assert property (cmd_fire && cmd[3:2] == 2'b01 |=> $stable(dig_sel)
		##1 o_dig_route == $past(dig_sel, 2))
		else $error("digital route moved on analog pick");
	AST_DIG_MUTE: assert property (cmd_fire && cmd <= fpsmc_pkg::FPSMC_DIG3 |-> ##2 o_mute)
		else $error("no mute on digital pick");
	AST_CMD_FLASH: assert property (cmd_fire && !standby ##1 !standby |=> o_led.command
		== fpsmc_pkg::FPSMC_BRIGHT)
		else $error("command indicator not lit");
	AST_RATE_DARK: assert property (!data_ok |=> o_rate_led == '0 && !o_enc_led)
		else $error("rate indicator lit without lock");
	AST_RESUME: assert property ($fell(standby) |-> warm_cnt == WW'(WARM_CYC))
		else $error("no warm-up after standby");

	COV_ANALOG: cover property (cmd_fire && cmd == fpsmc_pkg::FPSMC_ANA2);
	COV_STANDBY: cover property ($rose(standby) ##[1:50] $fell(standby));
	COV_REMOTE: cover property (cmd_fire && cmd_remote);
	COV_UNMUTE: cover property ($fell(o_mute));
endmodule

/* rtl/fpsmc_pkg.sv */
/*
 * Shared constants and types for the front panel selector and mute control.
 * Assumes a single 40 MHz clock and the panel-side block being the only user.
 */
package fpsmc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ     = 40000000;  // Core clock rate
	localparam longint unsigned WARM_S     = 20;        // Warm-up mute, seconds
	localparam longint unsigned DEB_MS     = 10;        // Least stable time of a press, ms
	localparam longint unsigned FLASH_MS   = 100;       // Command indicator flash, ms
	localparam longint unsigned WARM_CYC   = WARM_S * CLK_HZ;
	localparam longint unsigned DEB_CYC    = (DEB_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned FLASH_CYC  = (FLASH_MS * CLK_HZ) / 1000;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_SETTINGS = 4'h0;  // Read: held settings
	localparam logic [3:0] REG_LINKSTAT = 4'h4;  // Read: receiver and supply status
	localparam logic [3:0] REG_COMMAND  = 4'h8;  // Write: issue command, read: last command
	localparam int         CMD_W        = 4;     // Command code width
	localparam int         NBTN         = 12;    // Panel buttons
	localparam int         NRATE        = 4;     // Sample-rate indicators

	// ----------------------------------------------------------------
	// Commands: panel button index equals its code
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		FPSMC_DIG0    = 4'h0,
		FPSMC_DIG1    = 4'h1,
		FPSMC_DIG2    = 4'h2,
		FPSMC_DIG3    = 4'h3,
		FPSMC_ANA0    = 4'h4,
		FPSMC_ANA1    = 4'h5,
		FPSMC_ANA2    = 4'h6,
		FPSMC_ANA3    = 4'h7,
		FPSMC_PHASE   = 4'h8,
		FPSMC_INSERT  = 4'h9,
		FPSMC_OUT2    = 4'hA,
		FPSMC_OUT3    = 4'hB,
		FPSMC_MUTE    = 4'hC,
		FPSMC_STANDBY = 4'hD,
		FPSMC_VOLUP   = 4'hE,
		FPSMC_VOLDN   = 4'hF
	} fpsmc_cmd_t;

	// Indicator drive level
	typedef enum logic [1:0] {
		FPSMC_OFF    = 2'b00,
		FPSMC_DIM    = 2'b01,
		FPSMC_BRIGHT = 2'b10
	} fpsmc_lvl_t;

	// Pins arriving from outside the clock domain
	typedef struct packed {
		logic [NBTN-1:0]  btn;       // Panel buttons, high while pressed
		logic             rc_valid;  // Remote receiver holds a command
		logic [CMD_W-1:0] rc_code;   // Remote command code
		logic             lock;      // De-jitter receiver locked
		logic             dvalid;    // Incoming digital data valid
		logic [1:0]       rate;      // Sample-rate code
		logic             enc;       // Source carries special encoding
		logic             dec;       // Decoder active
		logic             indep;     // Independent-output jumper fitted
		logic             pgood;     // Supply present
	} fpsmc_pin_t;

	// Indicator bank
	typedef struct packed {
		fpsmc_lvl_t [3:0] dig;
		fpsmc_lvl_t [3:0] ana;
		fpsmc_lvl_t       phase;
		fpsmc_lvl_t       insert;
		fpsmc_lvl_t       out2;
		fpsmc_lvl_t       out3;
		fpsmc_lvl_t       mute;
		fpsmc_lvl_t       standby;
		fpsmc_lvl_t       command;
	} fpsmc_led_t;

endpackage

/* tb/fpsmc_panel_model.sv */
/*
 * Model of the panel buttons and the remote receiver.
 * Assumes the bench pulses i_go for one cycle while o_busy is low.
 */
module fpsmc_panel_model (
	input  wire logic        i_mclk,
	input  wire logic        i_go,
	input  wire logic        i_remote,
	input  wire logic [3:0]  i_code,
	input  wire logic [7:0]  i_hold,
	output logic [11:0]      o_btn,
	output logic             o_rc_valid,
	output logic [3:0]       o_rc_code,
	output logic             o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt = 9'h000;   // Press then release cycles left
	logic [7:0] hold_q = 8'h00; // Length of each phase
	logic [3:0] code_q = 4'h0;  // Code being sent
	logic       rem_q = 1'b0;   // Remote path rather than panel
	logic       act;            // Pin held in this cycle
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// A full release always follows, so a press is never merged
	always @(posedge i_mclk)
	begin
		if (i_go && !o_busy)
		begin
			cnt <= {i_hold, 1'b0};
			hold_q <= i_hold;
			code_q <= i_code;
			rem_q <= i_remote;
		end
		else if (cnt != 9'h000)
			cnt <= cnt - 9'h001;
	end
	assign o_busy = (cnt != 9'h000);
	assign act = (cnt > {1'b0, hold_q});
	// Both paths share one code space
	assign o_btn = (act && !rem_q) ? (12'h001 << code_q) : 12'h000;
	assign o_rc_valid = act && rem_q;
	// Code is meaningless outside valid: show its inverse, never a stale copy
	assign o_rc_code = o_rc_valid ? code_q : ~code_q;
endmodule

/* tb/test_front_panel_selector_mute_control.sv */
/*
 * Self-checking bench of the selector and mute control.
 * Assumes short counts: warm-up 200, debounce 4, flash 20 cycles.
 */
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_front_panel_selector_mute_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0;
	logic i_nrst = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0;
	logic wr = 1'b0, rd = 1'b0, lock = 1'b0, dval = 1'b0, enc = 1'b0, dec = 1'b0, indep = 1'b0, pg = 1'b1;
	logic go = 1'b0, rem = 1'b0;
	logic [1:0] rate = 2'h2;
	logic [3:0] code = 4'h0;
	logic [7:0] hold = 8'h0C;
	logic [11:0] btn;
	logic rcv, busy, srcv, phinv, ins_o, o2, o3, mute, pwr, vup, vdn, encl;
	logic [3:0] rcc, rled;
	logic [31:0] rdata, d;
	logic [1:0] droute, seen;
	logic [2:0] lsel;
	fpsmc_pkg::fpsmc_led_t led;
	fpsmc_pkg::fpsmc_pin_t pins;
	int n_errors = 0, check_count = 0, cyc = 0, i, c;
	// Reference settings, reset state first
	int dig = 0, asel = 0, ana = 0, src = 0, hd = 0, ph = 0, ins = 0, out2 = 0, out3 = 1, um = 0, sb = 0;
	// Jumper, code, path triples
	int tc[30] = '{0,8,2, 0,10,0, 0,11,1, 0,12,2, 0,12,0, 1,8,2, 1,11,0, 1,8,1, 1,10,1, 0,10,0};
	assign pins = '{btn: btn, rc_valid: rcv, rc_code: rcc, lock: lock, dvalid: dval, rate: rate, enc: enc,
		dec: dec, indep: indep, pgood: pg};
	fpsmc_top #(.WARM_CYC(200), .DEB_CYC(4), .FLASH_CYC(20)) fpsmc_top_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_pins(pins), .i_addr(adr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_dig_route(droute),
		.o_listen_sel(lsel), .o_src_valid(srcv), .o_phase_inv(phinv), .o_insert(ins_o), .o_out2_en(o2),
		.o_out3_en(o3), .o_mute(mute), .o_power_en(pwr), .o_vol_up(vup), .o_vol_dn(vdn), .o_led(led),
		.o_rate_led(rled), .o_enc_led(encl));
	fpsmc_panel_model fpsmc_panel_model_i (.i_mclk(i_mclk), .i_go(go), .i_remote(rem), .i_code(code),
		.i_hold(hold), .o_btn(btn), .o_rc_valid(rcv), .o_rc_code(rcc), .o_busy(busy));
	initial
	begin
		forever #12.5 i_mclk = ~i_mclk;
	end
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_mclk);
		adr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge i_mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_mclk);
		adr <= a;
		rd <= 1'b1;
		@(posedge i_mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Press and release; the volume outputs are caught mid-press
	task automatic press(input logic [3:0] k, input logic r, input logic [7:0] h);
		int j;
		@(posedge i_mclk);
		code <= k;
		rem <= r;
		hold <= h;
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		for (j = 0; j < 600 && (j < 2 || busy); j++)
		begin
			@(posedge i_mclk);
			#1;
			if (j == h) seen = {vup, vdn};
		end
		if (j == 600) n_errors++;
	endtask
	// Reference update for one accepted command
	task automatic apply(input int k, input int r);
		src = (k < 8) ? 1 : src;
		hd = (k < 4) ? 1 : hd;
		dig = (k < 4) ? k : dig;
		asel = (k > 3 && k < 8) ? k - 4 : asel;
		ana = (k < 4) ? 0 : (k < 8) ? 1 : ana;
		ph = (k == 8 && !(r && indep)) ? !ph : ph;
		ins = ins ^ (k == 9);
		um = um ^ (k == 12);
		sb = sb ^ (k == 13);
		if ((k == 10 || k == 11) && !indep)
		begin
			out3 = out2;
			out2 = !out3;
		end
		else if (indep)
		begin
			out2 = out2 ^ (k == 10 || (k == 8 && r));
			out3 = out3 ^ (k == 11);
		end
	endtask
	// Path: 0 register, 1 panel, 2 remote
	task automatic cmd(input int k, input int how);
		if (how == 0) wr_reg(4'h8, k);
		else press(k[3:0], how == 2, 8'h0C);
		apply(k, how == 2);
		repeat (6) @(posedge i_mclk);
		#1;
	endtask
	task automatic check_all;
		logic [31:0] v;
		rd_reg(4'h0, v);
		`CK("settings", (sb << 11) | (um << 10) | (out3 << 9) | (out2 << 8) | (ins << 7) | (ph << 6) | (src << 5) | (ana << 4) | (asel << 2) | dig, v);
		`CK("dig_route", dig, droute);
		`CK("listen_sel", ana ? 4 + asel : dig, lsel);
		if (src) `CK("phase_inv", ph && !ana, phinv);
		`CK("insert", ins, ins_o);
		`CK("out2_en", out2 && !sb, o2);
		`CK("out3_en", out3 && !sb, o3);
		`CK("power_en", !sb, pwr);
		`CK("mute", um || sb, mute);
		`CK("insert_led", sb ? 0 : ins ? 2 : 1, led.insert);
		`CK("src_valid", src, srcv);
		`CK("out2_led", sb ? 0 : out2 ? 2 : 1, led.out2);
		`CK("phase_led", sb ? 0 : ph ? 2 : 1, led.phase);
		if (ana) `CK("ana_led", sb ? 0 : 2, led.ana[asel]);
		if (hd) `CK("dig_led", sb ? 0 : 2, led.dig[dig]);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		c = $urandom(88);
		repeat (10) @(posedge i_mclk);
		#1;
		`CK("reset_mute", 1, mute);
		`CK("reset_led", 0, led);
		@(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		#1;
		`CK("warm_mute", 1, mute);
		`CK("rate_led", 0, rled);
		@(posedge i_mclk);
		lock <= 1'b1;
		dval <= 1'b1;
		repeat (200) @(posedge i_mclk);
		#1;
		`CK("warm_mute", 0, mute);
		`CK("mute_led", 1, led.mute);
		`CK("rate_led", 4'h4, rled);
		$display("test power-up done");
		for (i = 0; i < 8; i++)
		begin
			cmd(i, 1 + i % 2);
			check_all();
		end
		$display("test sources done");
		@(posedge i_mclk);
		lock <= 1'b0;
		cmd(1, 0);
		`CK("nodata_mute", 1, mute);
		`CK("rate_led", 0, rled);
		@(posedge i_mclk);
		lock <= 1'b1;
		enc <= 1'b1;
		repeat (6) @(posedge i_mclk);
		#1;
		`CK("nodata_mute", 0, mute);
		`CK("enc_led", 0, encl);
		@(posedge i_mclk);
		dec <= 1'b1;
		cmd(9, 0);
		`CK("enc_led", 1, encl);
		`CK("cmd_led", 2, led.command);
		repeat (30) @(posedge i_mclk);
		#1;
		`CK("cmd_led", 0, led.command);
		$display("test digital status done");
		for (i = 0; i < 30; i += 3)
		begin
			@(posedge i_mclk);
			indep <= tc[i][0];
			repeat (2) @(posedge i_mclk);
			cmd(tc[i + 1], tc[i + 2]);
			check_all();
		end
		for (c = 14; c < 16; c++)
		begin
			press(c[3:0], 1'b1, 8'h1E);
			`CK("vol", c == 14 ? 2 : 1, seen);
			`CK("vol_idle", 0, {vup, vdn});
		end
		$display("test toggles done");
		wr_reg(4'h0, 32'hFFFFFFFF);
		check_all();
		rd_reg(4'hC, d);
		`CK("unmapped", 0, d);
		rd_reg(4'h4, d);
		`CK("linkstat", {pg, indep, dec, enc, lock, dval}, d[6:1]);
		@(posedge i_mclk);
		#1;
		`CK("rdata_idle", 0, rdata);
		for (i = 0; i < 24; i++)
		begin
			cmd($urandom_range(11, 0), $urandom_range(2, 0));
			check_all();
		end
		$display("test random done");
		cmd(13, 2);
		check_all();
		`CK("stby_led", 1, led.standby);
		`CK("mute_led", 0, led.mute);
		`CK("rate_led", 0, rled);
		cmd(9, 0);
		check_all();
		cmd(13, 2);
		`CK("exit_mute", 1, mute);
		repeat (200) @(posedge i_mclk);
		#1;
		check_all();
		@(posedge i_mclk);
		pg <= 1'b0;
		repeat (4) @(posedge i_mclk);
		#1;
		`CK("supply_mute", 1, mute);
		$display("test standby done");
		tally_and_finish();
	end
endmodule
